//--- logic/ldrc_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - frame tick divides selected clock by 768, 576, 384, 288 or 192
// - aux pin select 0 then 1 outputs selected clock divided by two
// - supply drop detector puts system into reset, at power-up and later
// - reset blanks display, stops key scan, clears key data, ports low
// - reset forces shared segment/port pins to segment, aux pin to port, low
// - reset release enables display, key scan and port state settings
// - detector reset clears only on transfer strobe fall after all data
// - external reset pin low holds reset, high releases it
// - reset stops RC oscillator or external clock acceptance
// - display latch still accepts data while reset blanks display
// - reset returns key scan and port logic to initial state
// - serial interface and control register are untouched by reset
// - reset drives segments, commons, scans low; forces shared pin roles
// - oscillator pin is high impedance for the whole reset
// - open-drain key request stays released throughout reset
// - clock source select 0 picks RC oscillator, 1 external clock
module ldrc_ctrl #(
    parameter int unsigned DIV_W = ldrc_pkg::DIV_W
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire ldrc_pkg::ldrc_apb_req_t apb_req,
    output var  ldrc_pkg::ldrc_apb_rsp_t apb_rsp,
    input  wire logic                    supply_drop_detect,
    input  wire logic                    external_reset_n,
    input  wire logic                    transfer_enable,
    input  wire logic                    all_data_received,
    input  wire logic                    display_latch_strobe,
    output var  logic                    display_latch_we,
    input  wire logic                    rc_osc_clk,
    output var  logic                    rc_osc_run,
    input  wire logic                    oscillator_pin_in,
    output var  logic                    oscillator_pin_out,
    output var  logic                    oscillator_pin_oe_n,
    input  wire logic                    key_request,
    output var  logic                    key_request_out,
    output var  logic                    key_request_oe_n,
    output var  logic                    frame_tick,
    output var  ldrc_pkg::ldrc_pin_ctrl_t pin_ctrl
);

    // ------------------------------------------------------------
    // system reset state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_HOLD_SUPPLY_DROP_DETECT = 3'b001,
        ST_HOLD_PIN  = 3'b010,
        ST_RUN       = 3'b100
    } ldrc_state_t;

    ldrc_state_t state_ff;
    ldrc_state_t nxt_state;
    logic        ce_prev_ff;
    logic        nxt_ce_prev;
    logic        ce_fall;
    logic        sys_reset;

    assign ce_fall   = ce_prev_ff & ~transfer_enable;
    assign sys_reset = (state_ff != ST_RUN);

    always_comb begin
        nxt_ce_prev = transfer_enable;
        nxt_state   = state_ff;
        case (state_ff)
            ST_HOLD_SUPPLY_DROP_DETECT: begin
                if (supply_drop_detect) begin
                    nxt_state = ST_HOLD_SUPPLY_DROP_DETECT;
                end else if (ce_fall && all_data_received) begin
                    nxt_state = external_reset_n ? ST_RUN
                                                 : ST_HOLD_PIN;
                end
            end
            ST_HOLD_PIN: begin
                if (supply_drop_detect) begin
                    nxt_state = ST_HOLD_SUPPLY_DROP_DETECT;
                end else if (external_reset_n) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (supply_drop_detect) begin
                    nxt_state = ST_HOLD_SUPPLY_DROP_DETECT;
                end else if (!external_reset_n) begin
                    nxt_state = ST_HOLD_PIN;
                end
            end
            default: begin
                nxt_state = ST_HOLD_SUPPLY_DROP_DETECT;
            end
        endcase
    end

    // power-up starts held in detector reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= ST_HOLD_SUPPLY_DROP_DETECT;
            ce_prev_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            ce_prev_ff <= nxt_ce_prev;
        end
    end

    // ------------------------------------------------------------
    // registers, reset only by resetn, never by system reset
    // ------------------------------------------------------------
    logic [ldrc_pkg::CTRL_W-1:0]      ctrl_ff;
    logic [ldrc_pkg::CTRL_W-1:0]      nxt_ctrl;
    logic [ldrc_pkg::PORT_DATA_W-1:0] port_data_ff;
    logic [ldrc_pkg::PORT_DATA_W-1:0] nxt_port_data;
    logic [ldrc_pkg::PORT_FN_W-1:0]   port_fn_ff;
    logic [ldrc_pkg::PORT_FN_W-1:0]   nxt_port_fn;
    logic [31:0]                      prdata_ff;
    logic [31:0]                      nxt_prdata;
    logic                             pslverr_ff;
    logic                             nxt_pslverr;
    logic [31:0]                      rd_word;
    logic                             hit;
    logic                             setup;
    logic                             wr_access;
    logic [31:0]                      status_word;
    logic                             clk_out_ff;

    assign setup     = apb_req.psel & ~apb_req.penable;
    assign wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite;

    always_comb begin
        status_word = '0;
        status_word[ldrc_pkg::ST_SYSRST_BIT] = sys_reset;
        status_word[ldrc_pkg::ST_SUPPLY_DROP_DETECT_BIT]   = (state_ff == ST_HOLD_SUPPLY_DROP_DETECT);
        status_word[ldrc_pkg::ST_PIN_BIT]    = (state_ff == ST_HOLD_PIN);
        status_word[ldrc_pkg::ST_DISP_BIT]   = pin_ctrl.display_on;
        status_word[ldrc_pkg::ST_KSCAN_BIT]  = pin_ctrl.key_scan_en;
        status_word[ldrc_pkg::ST_CLKO_BIT]   = clk_out_ff;
    end

    always_comb begin
        hit     = 1'b1;
        rd_word = '0;
        case (apb_req.paddr)
            ldrc_pkg::OFS_CTRL: begin
                rd_word[ldrc_pkg::CTRL_W-1:0] = ctrl_ff;
            end
            ldrc_pkg::OFS_PORT: begin
                rd_word[ldrc_pkg::PORT_DATA_LSB +: ldrc_pkg::PORT_DATA_W] =
                    port_data_ff;
                rd_word[ldrc_pkg::PORT_FN_LSB +: ldrc_pkg::PORT_FN_W] =
                    port_fn_ff;
            end
            ldrc_pkg::OFS_STATUS: begin
                rd_word = status_word;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_ctrl      = ctrl_ff;
        nxt_port_data = port_data_ff;
        nxt_port_fn   = port_fn_ff;
        nxt_prdata    = prdata_ff;
        nxt_pslverr   = pslverr_ff;
        if (setup) begin
            nxt_prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
            nxt_pslverr = ~hit;
        end
        // writes land even in system reset
        if (wr_access && hit) begin
            case (apb_req.paddr)
                ldrc_pkg::OFS_CTRL: begin
                    nxt_ctrl = apb_req.pwdata[ldrc_pkg::CTRL_W-1:0];
                end
                ldrc_pkg::OFS_PORT: begin
                    nxt_port_data = apb_req.pwdata[ldrc_pkg::PORT_DATA_LSB
                                    +: ldrc_pkg::PORT_DATA_W];
                    nxt_port_fn   = apb_req.pwdata[ldrc_pkg::PORT_FN_LSB
                                    +: ldrc_pkg::PORT_FN_W];
                end
                default: begin
                    nxt_ctrl = ctrl_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff      <= ldrc_pkg::CTRL_RST;
            port_data_ff <= ldrc_pkg::PORT_DATA_RST;
            port_fn_ff   <= ldrc_pkg::PORT_FN_RST;
            prdata_ff    <= 32'h0000_0000;
            pslverr_ff   <= 1'b0;
        end else begin
            ctrl_ff      <= nxt_ctrl;
            port_data_ff <= nxt_port_data;
            port_fn_ff   <= nxt_port_fn;
            prdata_ff    <= nxt_prdata;
            pslverr_ff   <= nxt_pslverr;
        end
    end

    // read data is loaded in setup, so no wait state is needed
    always_comb begin
        apb_rsp.prdata  = prdata_ff;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = pslverr_ff & apb_req.psel & apb_req.penable;
    end

    // ------------------------------------------------------------
    // clock selection and gating
    // ------------------------------------------------------------
    logic       clk_src_sel;
    logic [1:0] aux_sel;
    logic       src_level;
    logic       src_prev_ff;
    logic       nxt_src_prev;
    logic       sel_tick;
    logic       nxt_clk_out;
    logic [DIV_W-1:0] frame_div;

    assign clk_src_sel = ctrl_ff[ldrc_pkg::CTRL_CSRC_BIT];
    assign aux_sel     = {ctrl_ff[ldrc_pkg::CTRL_AUXA_BIT],
                          ctrl_ff[ldrc_pkg::CTRL_AUXB_BIT]};

    always_comb begin
        src_level = (clk_src_sel == ldrc_pkg::CSRC_EXT) ? oscillator_pin_in
                                                         : rc_osc_clk;
    end

    assign nxt_src_prev = src_level;
    // no selected edges accepted in reset
    assign sel_tick = src_level & ~src_prev_ff & ~sys_reset;
    assign rc_osc_run = ~sys_reset
                      & (clk_src_sel == ldrc_pkg::CSRC_RC);

    always_comb begin
        nxt_clk_out = clk_out_ff;
        if (sys_reset || aux_sel != ldrc_pkg::AUX_SEL_CLOCK) begin
            nxt_clk_out = 1'b0;
        end else if (sel_tick) begin
            nxt_clk_out = ~clk_out_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_prev_ff <= 1'b0;
            clk_out_ff  <= 1'b0;
        end else begin
            src_prev_ff <= nxt_src_prev;
            clk_out_ff  <= nxt_clk_out;
        end
    end

    // ------------------------------------------------------------
    // frame divider
    // ------------------------------------------------------------
    always_comb begin
        case (ctrl_ff[ldrc_pkg::CTRL_FRS_LSB +: 3])
            ldrc_pkg::FRS_768: frame_div = DIV_W'(ldrc_pkg::DIV_768);
            ldrc_pkg::FRS_576: frame_div = DIV_W'(ldrc_pkg::DIV_576);
            ldrc_pkg::FRS_384: frame_div = DIV_W'(ldrc_pkg::DIV_384);
            ldrc_pkg::FRS_288: frame_div = DIV_W'(ldrc_pkg::DIV_288);
            ldrc_pkg::FRS_192: frame_div = DIV_W'(ldrc_pkg::DIV_192);
            default:           frame_div = DIV_W'(ldrc_pkg::DIV_384);
        endcase
    end

    ldrc_tick_div #(
        .W       (DIV_W)
    ) u_frame_div (
        .clk     (clk),
        .resetn  (resetn),
        .clear   (sys_reset),
        .tick    (sel_tick),
        .divisor (frame_div),
        .pulse   (frame_tick)
    );

    // ------------------------------------------------------------
    // pin and block control
    // ------------------------------------------------------------
    logic [ldrc_pkg::PORT_DATA_W-1:0] gp_level_ff;
    logic [ldrc_pkg::PORT_DATA_W-1:0] nxt_gp_level;

    // port levels drop on the very edge that enters reset, no lag
    always_comb begin
        nxt_gp_level = (nxt_state == ST_RUN) ? port_data_ff : '0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gp_level_ff <= '0;
        end else begin
            gp_level_ff <= nxt_gp_level;
        end
    end

    always_comb begin
        pin_ctrl.display_on        = ~sys_reset;
        pin_ctrl.key_scan_en       = ~sys_reset
                                   & ~ctrl_ff[ldrc_pkg::CTRL_KSD_BIT];
        pin_ctrl.key_data_clear    = sys_reset;
        pin_ctrl.drivers_force_low = sys_reset;
        pin_ctrl.com4_force_common = sys_reset;
        pin_ctrl.scan_seg_force_segment = sys_reset;
        pin_ctrl.seg_port_is_port  = sys_reset ? 4'h0 : port_fn_ff;
        pin_ctrl.seg_port_level    = gp_level_ff[3:0];
        pin_ctrl.gp_port_level     = gp_level_ff;
        pin_ctrl.aux_is_clock      = ~sys_reset
                                   & (aux_sel == ldrc_pkg::AUX_SEL_CLOCK);
        pin_ctrl.aux_is_port       = sys_reset
                                   | (aux_sel == ldrc_pkg::AUX_SEL_PORT);
        if (pin_ctrl.aux_is_clock) begin
            pin_ctrl.aux_level = clk_out_ff;
        end else begin
            pin_ctrl.aux_level = gp_level_ff[4];
        end
    end

    // latch keeps loading while the display is blanked
    assign display_latch_we = display_latch_strobe;

    // oscillator pin is never driven here, so it is high impedance in reset
    assign oscillator_pin_out  = 1'b0;
    assign oscillator_pin_oe_n = 1'b1;

    // open-drain request, released throughout reset
    assign key_request_out  = 1'b0;
    assign key_request_oe_n = ~(key_request & ~sys_reset);

endmodule : ldrc_ctrl
`default_nettype wire

//--- shared/ldrc_pkg.sv
`default_nettype none
package ldrc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned APB_AW    = 12;
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_PORT   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // control word fields
    localparam int unsigned CTRL_FRS_LSB  = 0;
    localparam int unsigned CTRL_AUXA_BIT = 3;
    localparam int unsigned CTRL_AUXB_BIT = 4;
    localparam int unsigned CTRL_CSRC_BIT = 5;
    localparam int unsigned CTRL_KSD_BIT  = 6;
    localparam int unsigned CTRL_DUTY_BIT = 7;
    localparam int unsigned CTRL_W        = 8;
    localparam logic [7:0]  CTRL_RST      = 8'h00;

    // port word fields
    localparam int unsigned PORT_DATA_LSB = 0;
    localparam int unsigned PORT_DATA_W   = 5;
    localparam int unsigned PORT_FN_LSB   = 8;
    localparam int unsigned PORT_FN_W     = 4;
    localparam logic [4:0]  PORT_DATA_RST = 5'h00;
    localparam logic [3:0]  PORT_FN_RST   = 4'h0;

    // status word fields
    localparam int unsigned ST_SYSRST_BIT = 0;
    localparam int unsigned ST_SUPPLY_DROP_DETECT_BIT   = 1;
    localparam int unsigned ST_PIN_BIT    = 2;
    localparam int unsigned ST_DISP_BIT   = 3;
    localparam int unsigned ST_KSCAN_BIT  = 4;
    localparam int unsigned ST_CLKO_BIT   = 5;

    // ------------------------------------------------------------
    // frame rate select, value is {sel_2, sel_1, sel_0}
    // ------------------------------------------------------------
    localparam int unsigned DIV_W   = 10;
    localparam logic [2:0]  FRS_768 = 3'h3;
    localparam logic [2:0]  FRS_576 = 3'h7;
    localparam logic [2:0]  FRS_384 = 3'h0;
    localparam logic [2:0]  FRS_288 = 3'h4;
    localparam logic [2:0]  FRS_192 = 3'h2;
    localparam logic [9:0]  DIV_768 = 10'h300;
    localparam logic [9:0]  DIV_576 = 10'h240;
    localparam logic [9:0]  DIV_384 = 10'h180;
    localparam logic [9:0]  DIV_288 = 10'h120;
    localparam logic [9:0]  DIV_192 = 10'h0c0;

    // aux pin function, value is {func_sel_a, func_sel_b}
    localparam logic [1:0]  AUX_SEL_PORT  = 2'h0;
    localparam logic [1:0]  AUX_SEL_CLOCK = 2'h1;

    // clock source select
    localparam logic        CSRC_RC  = 1'b0;
    localparam logic        CSRC_EXT = 1'b1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ldrc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ldrc_apb_rsp_t;

    typedef struct packed {
        logic       display_on;
        logic       key_scan_en;
        logic       key_data_clear;
        logic       drivers_force_low;
        logic       com4_force_common;
        logic       scan_seg_force_segment;
        logic [3:0] seg_port_is_port;
        logic [3:0] seg_port_level;
        logic [4:0] gp_port_level;
        logic       aux_is_port;
        logic       aux_is_clock;
        logic       aux_level;
    } ldrc_pin_ctrl_t;

endpackage : ldrc_pkg
`default_nettype wire

//--- logic/ldrc_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module ldrc_tick_div #(
    parameter int unsigned W = 10
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] divisor,
    output var  logic         pulse
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         pulse_ff;
    logic         nxt_pulse;

    // ------------------------------------------------------------
    // count selected clock ticks, pulse once per divisor ticks
    // ------------------------------------------------------------
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_pulse = 1'b0;
        if (clear) begin
            nxt_cnt = '0;
        end else if (tick) begin
            if (cnt_ff >= divisor - W'(1)) begin
                nxt_cnt   = '0;
                nxt_pulse = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;

endmodule : ldrc_tick_div
`default_nettype wire

//--- bench/ldrc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ldrc_ctrl_checker (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire logic                     supply_drop_detect,
    input wire logic                     external_reset_n,
    input wire logic                     display_latch_strobe,
    input wire logic                     display_latch_we,
    input wire logic                     rc_osc_run,
    input wire logic                     oscillator_pin_oe_n,
    input wire logic                     key_request,
    input wire logic                     key_request_oe_n,
    input wire logic                     frame_tick,
    input wire ldrc_pkg::ldrc_pin_ctrl_t pin_ctrl
);
    // ------------------------------------------------------------
    // reset and pin state properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    drop_reset_a: assert property (
        supply_drop_detect |=> !pin_ctrl.display_on)
        else $error("supply drop left display on");
    pin_reset_a: assert property (
        !external_reset_n |=> !pin_ctrl.display_on)
        else $error("reset pin low left display on");
    release_cause_a: assert property (
        $rose(pin_ctrl.display_on) |->
        $past(external_reset_n) && !$past(supply_drop_detect))
        else $error("release while a reset source active");
    blank_state_a: assert property (
        !pin_ctrl.display_on |-> pin_ctrl.key_data_clear &&
        !pin_ctrl.key_scan_en && pin_ctrl.drivers_force_low)
        else $error("reset did not blank or stop scan");
    gp_low_a: assert property (
        !pin_ctrl.display_on |-> pin_ctrl.gp_port_level == 5'h00 &&
        pin_ctrl.seg_port_level == 4'h0)
        else $error("port levels not low in reset");
    pin_roles_a: assert property (
        !pin_ctrl.display_on |-> pin_ctrl.seg_port_is_port == 4'h0 &&
        pin_ctrl.aux_is_port && !pin_ctrl.aux_level &&
        pin_ctrl.com4_force_common && pin_ctrl.scan_seg_force_segment)
        else $error("shared pin roles wrong in reset");
    osc_stop_a: assert property (
        !pin_ctrl.display_on |-> oscillator_pin_oe_n && !rc_osc_run)
        else $error("oscillator active in reset");
    key_req_a: assert property (
        key_request_oe_n == !(key_request && pin_ctrl.display_on))
        else $error("key request pin wrong");
    latch_we_a: assert property (
        display_latch_we == display_latch_strobe)
        else $error("latch write not following strobe");
    tick_pulse_a: assert property (
        frame_tick |=> !frame_tick)
        else $error("frame tick longer than one cycle");
endmodule : ldrc_ctrl_checker

bind ldrc_ctrl ldrc_ctrl_checker u_ldrc_ctrl_checker (
    .clk(clk), .resetn(resetn), .supply_drop_detect(supply_drop_detect),
    .external_reset_n(external_reset_n),
    .display_latch_strobe(display_latch_strobe),
    .display_latch_we(display_latch_we), .rc_osc_run(rc_osc_run),
    .oscillator_pin_oe_n(oscillator_pin_oe_n), .key_request(key_request),
    .key_request_oe_n(key_request_oe_n), .frame_tick(frame_tick),
    .pin_ctrl(pin_ctrl));
`default_nettype wire

//--- bench/ldrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldrc_host_model (
    input wire logic clk,
    output var logic transfer_enable,
    output var logic all_data_received,
    output var logic external_reset_n
);
    initial begin
        transfer_enable   = 1'b0;
        all_data_received = 1'b0;
        external_reset_n  = 1'b0;
    end
    // one framed transfer, last marks the full data set
    task automatic send(input logic last);
        @(posedge clk) transfer_enable <= 1'b1;
        repeat (4) @(posedge clk);
        all_data_received <= last;
        transfer_enable   <= 1'b0;
        @(posedge clk);
    endtask : send
    // bench raises the pin only after send(1)
    task automatic pin(input logic v);
        @(posedge clk) external_reset_n <= v;
    endtask : pin
endmodule : ldrc_host_model
`default_nettype wire

//--- bench/tb_ldrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ldrc_ctrl;
    logic clk = 1'b0, resetn = 1'b0;
    logic sdd = 1'b0, rco = 1'b0, opi = 1'b0, kreq = 1'b0, dls = 1'b0;
    logic dlw, run, opo, ooe, kro, koe, ft, te, adr, ern;
    ldrc_pkg::ldrc_apb_req_t  req = '0;
    ldrc_pkg::ldrc_apb_rsp_t  rsp;
    ldrc_pkg::ldrc_pin_ctrl_t pc;
    int miscompares = 0, n_tests = 0, cyc = 0, i;
    logic [2:0] codes [5] = '{3'h3, 3'h7, 3'h0, 3'h4, 3'h2};
    int divs [5] = '{768, 576, 384, 288, 192};

    always #10 clk = ~clk;

    ldrc_host_model u_ldrc_host_model (.clk(clk), .transfer_enable(te),
        .all_data_received(adr), .external_reset_n(ern));
    ldrc_ctrl u_ldrc_ctrl (.clk(clk), .resetn(resetn), .apb_req(req),
        .apb_rsp(rsp), .supply_drop_detect(sdd), .external_reset_n(ern),
        .transfer_enable(te), .all_data_received(adr),
        .display_latch_strobe(dls), .display_latch_we(dlw),
        .rc_osc_clk(rco), .rc_osc_run(run), .oscillator_pin_in(opi),
        .oscillator_pin_out(opo), .oscillator_pin_oe_n(ooe),
        .key_request(kreq), .key_request_out(kro),
        .key_request_oe_n(koe), .frame_tick(ft), .pin_ctrl(pc));

    // ------------------------------------------------------------
    // report and bus tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk_bit(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %b got %b", s, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string s, input logic [31:0] e,
                            input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk_word

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic er);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        if (!w) chk_word("prdata", e, rsp.prdata);
        chk_bit("pslverr", er, rsp.pslverr);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // edges between two frame ticks, aux pin in clock mode
    task automatic meas(input logic [2:0] c, input logic x, input int n);
        int k, t0, nt, tg, bad;
        logic a, f;
        apb(1'b1, 12'h000, {26'h0, x, 2'h2, c}, 32'h0, 1'b0);
        nt = 0; t0 = 0; tg = 0; bad = 0; a = pc.aux_level;
        for (k = 1; k <= 2 * n + 1024 && nt < 2; k++) begin
            if (x) opi <= 1'b1; else rco <= 1'b1;
            @(posedge clk);
            f = ft === 1'b1;
            if (x) opi <= 1'b0; else rco <= 1'b0;
            @(posedge clk);
            f = f | (ft === 1'b1);
            if (k > 1 && pc.aux_level === a) bad++;
            a = pc.aux_level;
            if (f) begin
                nt++;
                tg = k - t0;
                t0 = k;
            end
        end
        chk_word("frame divide", n, tg);
        chk_word("aux clock misses", 0, bad);
    endtask : meas

    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            miscompares++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        kreq <= 1'b1;
        dls  <= 1'b1;
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0003, 1'b0);
        chk_bit("latch we", 1'b1, dlw);
        chk_bit("key req oe_n", 1'b1, koe);
        chk_bit("osc oe_n", 1'b1, ooe);
        chk_bit("osc run", 1'b0, run);
        chk_bit("key clear", 1'b1, pc.key_data_clear);
        apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h004, 32'h0000_0f1f, 32'h0, 1'b0);
        apb(1'b1, 12'h008, 32'h0000_00ff, 32'h0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 32'h0000_0f1f, 1'b0);
        chk_word("gp level", 32'h0, {27'h0, pc.gp_port_level});
        chk_word("seg port", 32'h0, {28'h0, pc.seg_port_is_port});
        u_ldrc_host_model.send(1'b0);
        chk_bit("display on", 1'b0, pc.display_on);
        u_ldrc_host_model.send(1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0005, 1'b0);
        u_ldrc_host_model.pin(1'b1);
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0018, 1'b0);
        chk_bit("key req oe_n", 1'b0, koe);
        chk_word("gp level", 32'h1f, {27'h0, pc.gp_port_level});
        chk_bit("osc run", 1'b1, run);
        chk_word("pin outs", 32'h0, {30'h0, opo, kro});
        kreq <= 1'b0;
        dls  <= 1'b0;
        @(posedge clk);
        chk_bit("key req oe_n", 1'b1, koe);
        chk_bit("latch we", 1'b0, dlw);
        kreq <= 1'b1;
        u_ldrc_host_model.pin(1'b0);
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0005, 1'b0);
        u_ldrc_host_model.pin(1'b1);
        repeat (3) @(posedge clk);
        for (i = 0; i < 5; i++) meas(codes[i], 1'b0, divs[i]);
        meas(3'h2, 1'b1, 192);
        sdd <= 1'b1;
        @(posedge clk);
        sdd <= 1'b0;
        repeat (2) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0003, 1'b0);
        chk_bit("aux port", 1'b1, pc.aux_is_port);
        chk_bit("aux level", 1'b0, pc.aux_level);
        chk_bit("key req oe_n", 1'b1, koe);
        u_ldrc_host_model.send(1'b1);
        repeat (2) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0, 32'h0000_0018, 1'b0);
        test_done();
    end
endmodule : tb_ldrc_ctrl
`default_nettype wire
